// >>> design/sram_ctrl_consts.svh
// Timing and geometry constants for the async SRAM host controller
`ifndef SRAM_CTRL_CONSTS_SVH
`define SRAM_CTRL_CONSTS_SVH

`define SRAM_ADDR_W 17
`define SRAM_DATA_W 8
`define SRAM_CLK_PERIOD_NS 10
// Read access time, ns (address or select to data valid)
`define SRAM_T_ACCESS_NS 10
// Least store strobe pulse width, ns
`define SRAM_T_STORE_PULSE_NS 7
// Store strobe low to device data float, ns (longest)
`define SRAM_T_STORE_FLOAT_NS 5
// Least data setup to write end, ns
`define SRAM_T_DATA_SETUP_NS 5
// Least read cycle time, ns
`define SRAM_T_READ_CYCLE_NS 10
// Select high to data float, ns (longest)
`define SRAM_T_SEL_FLOAT_NS 5

// Cycle counts: least times round up, none below one cycle
`define SRAM_CEIL_CYC(ns) \
  ((((ns) + `SRAM_CLK_PERIOD_NS - 1) / `SRAM_CLK_PERIOD_NS) < 1 ? 1 : \
  (((ns) + `SRAM_CLK_PERIOD_NS - 1) / `SRAM_CLK_PERIOD_NS))
// Access time reaches the first sync flop; one more edge per sync flop
`define SRAM_READ_CYC (`SRAM_CEIL_CYC(`SRAM_T_ACCESS_NS) + 2)
`define SRAM_FLOAT_CYC `SRAM_CEIL_CYC(`SRAM_T_STORE_FLOAT_NS)
`define SRAM_STORE_CYC \
  `SRAM_CEIL_CYC(`SRAM_T_STORE_PULSE_NS + `SRAM_T_DATA_SETUP_NS)
`define SRAM_TURN_CYC `SRAM_CEIL_CYC(`SRAM_T_SEL_FLOAT_NS)
`define SRAM_CNT_W 4

`endif

// >>> design/sram_ctrl_pkg.sv
// Types for the async SRAM host controller
package sram_ctrl_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_WFLOAT,
    ST_WSTORE,
    ST_WEND,
    ST_TURN
  } state_t;
endpackage

// >>> design/sram_host_ctrl.sv
// Host controller driving a 128K x 8 asynchronous SRAM through its pins
//
// Functional notes
// - Write window is overlap of select low and store low; a rise ends it.
// - Write data setup and hold are timed from the write-ending strobe edge.
// - Strobe-governed write with drive enable low lasts float delay plus setup.
// - Host never drives data while the device may still drive at write start.
// - Read by select needs address valid before or as select falls.
`timescale 1ns/1ns
`default_nettype none
`include "sram_ctrl_consts.svh"

module sram_host_ctrl #(
  parameter int ADDR_W = `SRAM_ADDR_W,
  parameter int DATA_W = `SRAM_DATA_W
) (
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  // User request side
  input wire logic REQ_VALID_I,
  input wire logic REQ_WRITE_I,
  input wire logic [ADDR_W-1:0] REQ_ADDR_I,
  input wire logic [DATA_W-1:0] REQ_WDATA_I,
  output logic REQ_READY_O,
  output logic RD_VALID_O,
  output logic [DATA_W-1:0] RD_DATA_O,
  // SRAM pins
  output logic [ADDR_W-1:0] ADDR_LINES_O,
  output logic CHIP_SEL_N_O,
  output logic DRIVE_EN_N_O,
  output logic STORE_N_O,
  output logic [DATA_W-1:0] DATA_LINES_O,
  output logic DATA_LINES_OE_O,
  input wire logic [DATA_W-1:0] DATA_LINES_I
);

  localparam int CNT_W = `SRAM_CNT_W;
  localparam logic [`SRAM_CNT_W-1:0] READ_CYC = `SRAM_CNT_W'(`SRAM_READ_CYC);
  localparam logic [`SRAM_CNT_W-1:0] FLOAT_CYC =
    `SRAM_CNT_W'(`SRAM_FLOAT_CYC);
  localparam logic [`SRAM_CNT_W-1:0] STORE_CYC =
    `SRAM_CNT_W'(`SRAM_STORE_CYC);
  localparam logic [`SRAM_CNT_W-1:0] TURN_CYC = `SRAM_CNT_W'(`SRAM_TURN_CYC);

  sram_ctrl_pkg::state_t state_reg;
  logic [`SRAM_CNT_W-1:0] cnt_reg;
  logic [DATA_W-1:0] din_meta_reg;
  logic [DATA_W-1:0] din_sync_reg;
  // Shared decodes of the sequencer state
  logic accept;
  logic read_last;
  logic wfloat_last;
  logic wstore_last;
  logic turn_last;

  // Timed states leave on the edge at which the down-counter reads one;
  // the counter is loaded with the full count as the state is entered
  function automatic logic at_last(input logic [CNT_W-1:0] cnt);
    return cnt == CNT_W'(1'b1);
  endfunction

  // Acceptance and the last cycle of each timed state drive the pins,
  // the data driver, the read capture and ready from one place, so the
  // processes below cannot disagree on when a phase ends
  assign accept = state_reg == sram_ctrl_pkg::ST_IDLE && REQ_VALID_I;
  assign read_last = state_reg == sram_ctrl_pkg::ST_READ && at_last(cnt_reg);
  assign wfloat_last = state_reg == sram_ctrl_pkg::ST_WFLOAT &&
    at_last(cnt_reg);
  assign wstore_last = state_reg == sram_ctrl_pkg::ST_WSTORE &&
    at_last(cnt_reg);
  assign turn_last = state_reg == sram_ctrl_pkg::ST_TURN && at_last(cnt_reg);

  // Pin data is asynchronous to our clock; two flops before any use
  // Only the data lines come back from the pins; everything else is ours
  always_ff @(posedge SYS_CLK_I) begin
    din_meta_reg <= DATA_LINES_I;
    din_sync_reg <= din_meta_reg;
  end

  // Read walk: select and drive enable fall on the accepting edge; the
  // first sync flop samples the pins one access time later and the byte
  // is taken two edges after that, on the edge that raises select again.
  // A slower part or longer board traces need a larger access constant;
  // the sync flops cost two cycles of latency but keep the capture safe.
  // Write walk: store falls with select while our driver stays off for
  // the float delay, then data is driven for the store pulse plus setup.
  // Store rises alone, and select and the driver follow one edge later,
  // so the store edge always ends the write and the data hold is a full
  // clock. Address and data are held from acceptance to the next one.
  // A turn cycle with select high follows every access so the part can
  // release the bus before the next select.
  // Sequencer: one access at a time, strobes move only on clock edges
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      state_reg <= sram_ctrl_pkg::ST_IDLE;
      cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        sram_ctrl_pkg::ST_IDLE: begin
          if (REQ_VALID_I) begin
            state_reg <= REQ_WRITE_I ? sram_ctrl_pkg::ST_WFLOAT
                                     : sram_ctrl_pkg::ST_READ;
            cnt_reg <= REQ_WRITE_I ? FLOAT_CYC : READ_CYC;
          end
        end
        sram_ctrl_pkg::ST_READ: begin
          // Two extra cycles cover the two-flop sampling delay of the data
          if (cnt_reg == 1) begin
            state_reg <= sram_ctrl_pkg::ST_TURN;
            cnt_reg <= TURN_CYC;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        sram_ctrl_pkg::ST_WFLOAT: begin
          // Store is low but our driver stays off until the device floats
          if (cnt_reg == 1) begin
            state_reg <= sram_ctrl_pkg::ST_WSTORE;
            cnt_reg <= STORE_CYC;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        sram_ctrl_pkg::ST_WSTORE: begin
          if (cnt_reg == 1) begin
            state_reg <= sram_ctrl_pkg::ST_WEND;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        sram_ctrl_pkg::ST_WEND: begin
          state_reg <= sram_ctrl_pkg::ST_TURN;
          cnt_reg <= TURN_CYC;
        end
        sram_ctrl_pkg::ST_TURN: begin
          // Deselected gap lets the device release the bus
          if (cnt_reg == 1) begin
            state_reg <= sram_ctrl_pkg::ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
      endcase
    end
  end

  // Address is latched at acceptance and held until the next one
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      ADDR_LINES_O <= '0;
      DATA_LINES_O <= '0;
    end else if (accept) begin
      ADDR_LINES_O <= REQ_ADDR_I;
      DATA_LINES_O <= REQ_WDATA_I;
    end
  end

  // Strobes; select and address change in the same edge for reads
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      CHIP_SEL_N_O <= 1'b1;
      DRIVE_EN_N_O <= 1'b1;
      STORE_N_O <= 1'b1;
    end else if (accept) begin
      CHIP_SEL_N_O <= 1'b0;
      DRIVE_EN_N_O <= REQ_WRITE_I;
      STORE_N_O <= !REQ_WRITE_I;
    end else if (wstore_last) begin
      // Store alone rises and ends the write; select stays low one more
      // cycle so the ending edge is unambiguous
      STORE_N_O <= 1'b1;
    end else if (read_last || state_reg == sram_ctrl_pkg::ST_WEND) begin
      CHIP_SEL_N_O <= 1'b1;
      DRIVE_EN_N_O <= 1'b1;
      STORE_N_O <= 1'b1;
    end
  end

  // Data driver: on only in the store phase and the hold cycle after it
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      DATA_LINES_OE_O <= 1'b0;
    end else if (wfloat_last) begin
      DATA_LINES_OE_O <= 1'b1;
    end else if (state_reg == sram_ctrl_pkg::ST_WEND) begin
      DATA_LINES_OE_O <= 1'b0; // Held one cycle past store rise
    end
  end

  // Read data capture from the synchronised lines
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      RD_VALID_O <= 1'b0;
      RD_DATA_O <= '0;
    end else begin
      RD_VALID_O <= read_last;
      if (read_last) begin
        RD_DATA_O <= din_sync_reg;
      end
    end
  end

  // Ready registered: high only while idle, low from the edge that accepts
  // A request held while busy is not taken and nothing is queued
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      REQ_READY_O <= 1'b0;
    end else if (state_reg == sram_ctrl_pkg::ST_IDLE) begin
      REQ_READY_O <= !REQ_VALID_I;
    end else begin
      REQ_READY_O <= turn_last;
    end
  end

endmodule
`default_nettype wire

// >>> bench/sram_host_ctrl_assertions.sv
// Pin protocol checker for the SRAM host controller
`timescale 1ns/1ns
`default_nettype none
module sram_host_ctrl_chk #(
  parameter int ADDR_W = 17,
  parameter int DATA_W = 8
) (
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic RD_VALID_O,
  input wire logic [ADDR_W-1:0] ADDR_LINES_O,
  input wire logic CHIP_SEL_N_O,
  input wire logic DRIVE_EN_N_O,
  input wire logic STORE_N_O,
  input wire logic [DATA_W-1:0] DATA_LINES_O,
  input wire logic DATA_LINES_OE_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // Store edge must end the write, so select stays low one cycle longer
  AST_STORE_ENDS: assert property ($rose(STORE_N_O) |->
    !CHIP_SEL_N_O ##1 CHIP_SEL_N_O) else $error("select not held");
  AST_STORE_IN_SEL: assert property (!STORE_N_O |->
    !CHIP_SEL_N_O) else $error("store outside select");
  AST_DATA_HOLD: assert property ($rose(STORE_N_O) |->
    DATA_LINES_OE_O && $stable(DATA_LINES_O)) else $error("data hold");
  AST_WR_LEN: assert property ($rose(STORE_N_O) |->
    $past(STORE_N_O, 3) == 1'b0 && $past(DATA_LINES_OE_O, 2))
    else $error("write too short");
  // Driving only after a cycle of store low lets the memory float first
  AST_NO_CLASH: assert property (DATA_LINES_OE_O |->
    $past(STORE_N_O) == 1'b0) else $error("host drove too early");
  AST_RD_QUIET: assert property (!DRIVE_EN_N_O |->
    !DATA_LINES_OE_O && STORE_N_O) else $error("drive during read");
  AST_ADDR_HELD: assert property (!CHIP_SEL_N_O &&
    $past(CHIP_SEL_N_O) == 1'b0 |-> $stable(ADDR_LINES_O))
    else $error("address moved while selected");
  AST_WR_ADDR: assert property (!STORE_N_O |=>
    STORE_N_O || $stable(ADDR_LINES_O)) else $error("write address moved");
  cover property ($fell(CHIP_SEL_N_O) && STORE_N_O);
  cover property ($rose(STORE_N_O));
  cover property (RD_VALID_O);
endmodule
`default_nettype wire

// >>> bench/sram_model.sv
// Behavioural model of the 128K x 8 asynchronous static memory
`timescale 1ns/1ns
`default_nettype none
module sram_model (
  input wire logic [16:0] addr_lines_i,
  input wire logic cs_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic host_oe_i,
  input wire logic [7:0] host_data_i,
  output logic [7:0] data_lines_o
);
  logic [7:0] mem [0:131071];
  logic [7:0] last = 8'h00;
  logic wr;
  logic drv;
  // Write window is the overlap; either strobe rising closes it
  assign wr = !cs_n_i && !we_n_i;
  assign drv = !cs_n_i && !oe_n_i && we_n_i;
  always @(negedge wr) mem[addr_lines_i] = host_oe_i ? host_data_i : 'x;
  // Remember the last driven value so a floating bus cannot look valid
  always @* if (drv) last = mem[addr_lines_i];
    else if (host_oe_i) last = host_data_i;
  assign data_lines_o = host_oe_i ? (drv ? 'x : host_data_i) :
    (drv ? mem[addr_lines_i] : ~last);
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the SRAM host controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 1'b0, rst = 1'b1, valid = 1'b0, wr = 1'b0;
  logic [16:0] addr = 17'h00000, a_o;
  logic [7:0] wd = 8'h00, rd, dout, din;
  logic rdy, rv, cs_n, oe_n, we_n, doe;
  int err_count = 0, n_compared = 0;
  always #5 clk = ~clk;
  sram_host_ctrl dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .REQ_VALID_I(valid),
    .REQ_WRITE_I(wr), .REQ_ADDR_I(addr), .REQ_WDATA_I(wd), .REQ_READY_O(rdy),
    .RD_VALID_O(rv), .RD_DATA_O(rd), .ADDR_LINES_O(a_o), .CHIP_SEL_N_O(cs_n),
    .DRIVE_EN_N_O(oe_n), .STORE_N_O(we_n), .DATA_LINES_O(dout),
    .DATA_LINES_OE_O(doe), .DATA_LINES_I(din));
  sram_model mdl (.addr_lines_i(a_o), .cs_n_i(cs_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .host_oe_i(doe), .host_data_i(dout), .data_lines_o(din));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("compared=%0d mismatches=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Hold the request until ready is seen, then release after the take edge
  task automatic req(input logic w, input logic [16:0] a, input logic [7:0] d);
    int i;
    @(posedge clk);
    valid <= 1'b1; wr <= w; addr <= a; wd <= d;
    i = 0;
    do begin @(negedge clk); i++; end while (rdy !== 1'b1 && i < 20);
    if (rdy !== 1'b1) begin err_count++; tally_and_finish(); end
    @(posedge clk);
    valid <= 1'b0;
  endtask
  task automatic rd_chk(input logic [16:0] a, input logic [7:0] e);
    int i;
    req(1'b0, a, 8'h00);
    i = 0;
    do begin @(negedge clk); i++; end while (rv !== 1'b1 && i < 10);
    chk({7'h00, rv}, 8'h01);
    chk(rd, e);
    if (rv !== 1'b1) begin err_count++; tally_and_finish(); end
  endtask
  // Pins idle and ready low until the first edge after release
  task t_reset;
    @(negedge clk);
    chk({2'h0, rdy, rv, cs_n, oe_n, we_n, doe}, 8'h0e);
    @(negedge clk);
    chk({7'h00, rdy}, 8'h01);
    chk(rd, 8'h00);
    $display("test reset done");
  endtask
  // Extreme addresses and both polarities of every data bit
  task t_bounds;
    logic [16:0] al [3];
    logic [7:0] dl [3];
    al = '{17'h00000, 17'h1ffff, 17'h0aaaa};
    dl = '{8'h5a, 8'hc3, 8'h0f};
    for (int k = 0; k < 2; k++) begin
      for (int j = 0; j < 3; j++) req(1'b1, al[j], dl[j] ^ {8{k[0]}});
      for (int j = 0; j < 3; j++) rd_chk(al[j], dl[j] ^ {8{k[0]}});
    end
    $display("test bounds done");
  endtask
  task t_overwrite;
    req(1'b1, 17'h00001, 8'h11);
    req(1'b1, 17'h00001, 8'hee);
    rd_chk(17'h00001, 8'hee);
    rd_chk(17'h00000, 8'ha5);
    @(negedge clk);
    chk({7'h00, doe}, 8'h00);
    $display("test overwrite done");
  endtask
  // Reset in mid-write: pins go idle at once, the memory keeps its data
  task t_mid_reset;
    int i;
    @(posedge clk);
    valid <= 1'b1;
    wr <= 1'b1;
    addr <= 17'h00002;
    wd <= 8'h3c;
    i = 0;
    do begin @(negedge clk); i++; end while (we_n !== 1'b0 && i < 20);
    if (we_n !== 1'b0) begin err_count++; tally_and_finish(); end
    @(posedge clk);
    valid <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({2'h0, rdy, rv, cs_n, oe_n, we_n, doe}, 8'h0e);
    @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({2'h0, rdy, rv, cs_n, oe_n, we_n, doe}, 8'h0e);
    @(negedge clk);
    chk({7'h00, rdy}, 8'h01);
    rd_chk(17'h00001, 8'hee);
    req(1'b1, 17'h00003, 8'h69);
    rd_chk(17'h00003, 8'h69);
    $display("test mid reset done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_bounds();
    t_overwrite();
    t_mid_reset();
    tally_and_finish();
  end
endmodule
bind sram_host_ctrl sram_host_ctrl_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
  chk (.SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .RD_VALID_O(RD_VALID_O),
  .ADDR_LINES_O(ADDR_LINES_O), .CHIP_SEL_N_O(CHIP_SEL_N_O),
  .DRIVE_EN_N_O(DRIVE_EN_N_O), .STORE_N_O(STORE_N_O),
  .DATA_LINES_O(DATA_LINES_O), .DATA_LINES_OE_O(DATA_LINES_OE_O));
`default_nettype wire
